// >>> cond_self_test_done_event_irq_regs.sv
// Top of the condition code, self-test status and second interrupt enable register bank.
// Assumes the host port presents one-cycle read and write strobes with a word address.
`timescale 1ns/1ps
module cond_self_test_done_event_irq_regs
  import cond_regs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Host register port.
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [4:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_hit,
  // Controller mode and message outcome.
  input wire logic enhanced_controller_active,
  input wire logic msg_done,
  input wire logic [1:0] msg_retries,
  input wire logic msg_error,
  input wire logic msg_loopback_fail,
  input wire logic msg_format_error,
  input wire logic msg_no_response,
  input wire logic msg_timeout,
  // Flag instruction and compares.
  input wire logic flag_instruction,
  input wire logic [15:0] flag_instruction_word,
  input wire logic compare_valid,
  input wire logic compare_equal,
  input wire logic compare_other,
  // Self-test state.
  input wire logic [4:0] proto_test_state,
  input wire logic [2:0] mem_test_state,
  // Interrupt events.
  input wire logic instruction_parity_error,
  input wire logic illegal_command_event,
  input wire logic queue_rollover,
  input wire logic call_stack_error,
  input wire logic illegal_opcode_event,
  input wire logic term_cmd_stack_half,
  input wire logic term_circ_buffer_half,
  input wire logic monitor_cmd_stack_half,
  input wire logic monitor_data_stack_half,
  input wire logic request_instruction,
  input wire logic [15:0] request_parameter,
  input wire logic self_test_done_event,
  // Second status register view and gated events.
  output logic [15:0] event_status,
  output logic [15:0] event_pulse,
  output logic [15:0] interrupt_request
);
  logic [15:0] second_interrupt_enable;
  logic [1:0] retry_count;
  logic failed_message_flag;
  logic format_error_flag;
  logic no_response_flag;
  logic [7:0] flags;
  logic [5:0] general_flags_upper;
  logic general_flag_equal;
  logic general_flag_compare;
  logic [15:0] controller_condition_code;
  logic [15:0] self_test_status_flags;
  logic [3:0] controller_request_bits;
  logic [15:0] next_event;
  logic cond_write;
  outcome_state_t outcome_state;

  ////////////////////////////////////////////////////////////////////////////
  // Host decode.
  assign cond_write = host_wr && host_addr == ADDR_COND_FLAGS;

  always_comb begin
    if (host_addr == ADDR_COND_FLAGS) begin
      host_hit = 1'b1;
    end else if (host_addr == ADDR_SELF_TEST) begin
      host_hit = 1'b1;
    end else if (host_addr == ADDR_INT_ENABLE2) begin
      host_hit = 1'b1;
    end else begin
      host_hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_rdata <= RESET_WORD;
    end else if (host_rd) begin
      if (host_addr == ADDR_COND_FLAGS) begin
        host_rdata <= controller_condition_code;
      end else if (host_addr == ADDR_SELF_TEST) begin
        host_rdata <= self_test_status_flags;
      end else if (host_addr == ADDR_INT_ENABLE2) begin
        host_rdata <= second_interrupt_enable;
      end else begin
        host_rdata <= RESET_WORD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      second_interrupt_enable <= RESET_WORD;
    end else if (host_wr && host_addr == ADDR_INT_ENABLE2) begin
      second_interrupt_enable <= host_wdata & ENABLE2_USED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message outcome.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outcome_state <= OUTCOME_IDLE;
      retry_count <= RETRY_NONE;
      failed_message_flag <= 1'b0;
      format_error_flag <= 1'b0;
      no_response_flag <= 1'b0;
    end else if (msg_done) begin
      outcome_state <= OUTCOME_DONE;
      case (msg_retries)
        2'h0: retry_count <= RETRY_NONE;
        2'h1: retry_count <= RETRY_ONE;
        default: retry_count <= RETRY_TWO;
      endcase
      failed_message_flag <= msg_error || msg_loopback_fail || msg_no_response
        || msg_timeout;
      format_error_flag <= msg_format_error;
      no_response_flag <= msg_no_response || msg_timeout;
    end
  end

  general_flags u_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .host_we(cond_write),
    .host_wdata(host_wdata),
    .flag_instruction(flag_instruction),
    .flag_instruction_word(flag_instruction_word),
    .compare_valid(compare_valid),
    .compare_equal(compare_equal),
    .compare_other(compare_other),
    .flags(flags)
  );

  assign general_flags_upper = flags[7:2];
  assign general_flag_equal = flags[1];
  assign general_flag_compare = flags[0];

  always_comb begin
    controller_condition_code = RESET_WORD;
    controller_condition_code[POS_ENH] = enhanced_controller_active;
    controller_condition_code[POS_RETRY +: 2] = retry_count;
    controller_condition_code[POS_FAIL] = failed_message_flag;
    controller_condition_code[POS_FORMAT] = format_error_flag;
    controller_condition_code[POS_NO_RESPONSE_FLAG] = no_response_flag;
    controller_condition_code[7:2] = general_flags_upper;
    controller_condition_code[1] = general_flag_equal;
    controller_condition_code[0] = general_flag_compare;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-test status.
  always_comb begin
    self_test_status_flags = RESET_WORD;
    self_test_status_flags[POS_PROTO +: 5] = proto_test_state;
    self_test_status_flags[POS_MEM +: 3] = mem_test_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second status and gated interrupts.
  always_comb begin
    next_event = RESET_WORD;
    next_event[14] = instruction_parity_error;
    next_event[13] = illegal_command_event;
    next_event[12] = queue_rollover;
    next_event[11] = call_stack_error;
    next_event[10] = illegal_opcode_event;
    next_event[9] = term_cmd_stack_half;
    next_event[8] = term_circ_buffer_half;
    next_event[7] = monitor_cmd_stack_half;
    next_event[6] = monitor_data_stack_half;
    if (request_instruction) begin
      next_event[POS_REQ +: 4] = request_parameter[3:0];
    end
    next_event[1] = self_test_done_event;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      controller_request_bits <= 4'h0;
    end else if (request_instruction) begin
      controller_request_bits <= request_parameter[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      event_status <= RESET_WORD;
      event_pulse <= RESET_WORD;
      interrupt_request <= RESET_WORD;
    end else begin
      event_status[15:6] <= event_status[15:6] | next_event[15:6];
      event_status[1] <= event_status[1] | next_event[1];
      event_status[POS_REQ +: 4] <= request_instruction ? request_parameter[3:0]
        : controller_request_bits;
      event_pulse <= next_event;
      interrupt_request <= next_event & second_interrupt_enable;
    end
  end

  a_retry_code_legal: assert property (@(posedge clk) disable iff (sys_rst)
    retry_count != 2'h2)
    else $error("retry code 10 produced");
  a_enh_bit_follows: assert property (@(posedge clk) disable iff (sys_rst)
    host_rd && host_addr == ADDR_COND_FLAGS |=>
      host_rdata[15] == $past(enhanced_controller_active))
    else $error("enhanced bit wrong");
  a_fail_on_no_response_flag: assert property (@(posedge clk) disable iff (sys_rst)
    msg_done && msg_no_response |=> failed_message_flag && no_response_flag)
    else $error("no response not flagged");
  a_format_follows: assert property (@(posedge clk) disable iff (sys_rst)
    msg_done |=> format_error_flag == $past(msg_format_error))
    else $error("format flag wrong");
  a_timeout_no_response_flag: assert property (@(posedge clk) disable iff (sys_rst)
    msg_done && msg_timeout |=> no_response_flag)
    else $error("timeout not flagged");
  a_outcome_idle_zero: assert property (@(posedge clk) disable iff (sys_rst)
    outcome_state == OUTCOME_IDLE |-> controller_condition_code[14:8] == 7'h00)
    else $error("outcome fields set before any message");
  a_self_test_done_event_zero_bits: assert property (@(posedge clk) disable iff (sys_rst)
    host_rd && host_addr == ADDR_SELF_TEST |=> (host_rdata & 16'h071f) == 16'h0000)
    else $error("self-test zero bits set");
  a_self_test_done_event_proto_read: assert property (@(posedge clk) disable iff (sys_rst)
    host_rd && host_addr == ADDR_SELF_TEST |=> host_rdata[15:11] == $past(proto_test_state))
    else $error("protocol test field wrong");
  a_self_test_done_event_mem_read: assert property (@(posedge clk) disable iff (sys_rst)
    host_rd && host_addr == ADDR_SELF_TEST |=> host_rdata[7:5] == $past(mem_test_state))
    else $error("memory test field wrong");
  a_shared_write: assert property (@(posedge clk) disable iff (sys_rst)
    host_wr && host_addr == ADDR_COND_FLAGS |=>
      second_interrupt_enable == $past(second_interrupt_enable))
    else $error("condition write reached enable");
  a_unused_enable: assert property (@(posedge clk) disable iff (sys_rst)
    second_interrupt_enable[15] == 1'b0 && second_interrupt_enable[0] == 1'b0)
    else $error("unused enable bit set");
  a_flag_instr_clear: assert property (@(posedge clk) disable iff (sys_rst)
    flag_instruction && !compare_valid |=>
      (flags & $past(flag_instruction_word[15:8])) == 8'h00)
    else $error("flag instruction clear lost");
  a_compare_loads: assert property (@(posedge clk) disable iff (sys_rst)
    compare_valid |=> flags[1:0] == $past({compare_equal, compare_other}))
    else $error("compare result not loaded");
  a_mask_gates_irq: assert property (@(posedge clk) disable iff (sys_rst)
    instruction_parity_error && !second_interrupt_enable[14] |=>
      !interrupt_request[14] && event_status[14])
    else $error("masked event raised interrupt");
  a_half_full_irq: assert property (@(posedge clk) disable iff (sys_rst)
    term_cmd_stack_half && second_interrupt_enable[9] |=> interrupt_request[9])
    else $error("half-full interrupt missing");
  a_opcode_status: assert property (@(posedge clk) disable iff (sys_rst)
    illegal_opcode_event |=> event_status[10])
    else $error("illegal opcode not recorded");
  a_enabled_irq: assert property (@(posedge clk) disable iff (sys_rst)
    self_test_done_event && second_interrupt_enable[1] |=> interrupt_request[1])
    else $error("enabled interrupt missing");
  a_status_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    event_status[9] |=> event_status[9])
    else $error("status bit lost");
  a_req_bits_take: assert property (@(posedge clk) disable iff (sys_rst)
    request_instruction |=> event_status[5:2] == $past(request_parameter[3:0]))
    else $error("request bits wrong");
endmodule : cond_self_test_done_event_irq_regs

// >>> cond_regs_pkg.sv
// Constants, offsets, field positions and reset values of the condition, self-test and
// second interrupt enable register bank.
// Assumes a 16-bit host register port with a word address, running on clk.
// Operation
// - Condition code top bit reads one while enhanced controller mode is active.
// - Retry field reports 00, 01 or 11 retries; code 10 never produced.
// - Failed-message flag set on errors, loopback failure or no response.
// - Format-error flag set when remote terminal response had format error.
// - No-response flag set on no response or response timeout.
// - Flags 7 to 2 set and cleared by host and flag instruction only.
// - Flag 1 is compare equal result, flag 0 another compare result.
// - Shared address: read gives condition code, write goes to flag port.
// - Upper byte bit n clears flag n, lower byte bit n sets it.
// - Self-test bits 15 to 11 report protocol test progress and result.
// - Self-test bits 7, 6, 5 report memory test complete, running, passed.
// - Self-test bits 10 to 8 and 4 to 0 read zero.
// - Enable one raises interrupt on event, zero masks; status set anyway.
// - Enable bit 14 gates instruction parity error interrupt.
// - Enable bit 13 gates illegal command or monitor stored message interrupt.
// - Enable bit 12 gates queue rollover interrupt.
// - Enable bit 11 gates call stack overflow or underflow interrupt.
// - Enable bit 10 gates illegal opcode fetch interrupt.
// - Enable bits 9 to 6 gate the four half-full interrupts in order.
// - Enable bits 5 to 2 gate controller interrupt request instruction interrupts.
// - Enable bit 1 gates self-test done interrupt; bits 15 and 0 unused.
// - Event status bits set on event at enable position regardless of enable.
// - Request status bits take low four bits of request parameter.
package cond_regs_pkg;
  localparam logic [4:0] ADDR_COND_FLAGS = 5'h1b;
  localparam logic [4:0] ADDR_SELF_TEST = 5'h1c;
  localparam logic [4:0] ADDR_INT_ENABLE2 = 5'h1d;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] ENABLE2_USED = 16'h7ffe;
  localparam int POS_ENH = 15;
  localparam int POS_RETRY = 13;
  localparam int POS_FAIL = 12;
  localparam int POS_FORMAT = 9;
  localparam int POS_NO_RESPONSE_FLAG = 8;
  localparam int POS_PROTO = 11;
  localparam int POS_MEM = 5;
  localparam int POS_REQ = 2;
  localparam logic [1:0] RETRY_NONE = 2'h0;
  localparam logic [1:0] RETRY_ONE = 2'h1;
  localparam logic [1:0] RETRY_TWO = 2'h3;
  typedef enum logic [1:0] {
    OUTCOME_IDLE = 2'b00,
    OUTCOME_DONE = 2'b01
  } outcome_state_t;
endpackage : cond_regs_pkg

// >>> general_flags.sv
// General purpose flag word with host set/clear port, flag instruction and compare results.
// Assumes single-cycle strobes synchronous to clk.
`timescale 1ns/1ps
module general_flags
  import cond_regs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Host write port.
  input wire logic host_we,
  input wire logic [15:0] host_wdata,
  // Flag instruction port.
  input wire logic flag_instruction,
  input wire logic [15:0] flag_instruction_word,
  // Compare results.
  input wire logic compare_valid,
  input wire logic compare_equal,
  input wire logic compare_other,
  // Flags.
  output logic [7:0] flags
);
  logic [7:0] next_flags;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;

  always_comb begin
    set_mask = 8'h00;
    clr_mask = 8'h00;
    if (host_we) begin
      set_mask = set_mask | host_wdata[7:0];
      clr_mask = clr_mask | host_wdata[15:8];
    end
    if (flag_instruction) begin
      set_mask = set_mask | flag_instruction_word[7:0];
      clr_mask = clr_mask | flag_instruction_word[15:8];
    end
    next_flags = (flags | set_mask) & ~clr_mask;
    if (compare_valid) begin
      next_flags[1] = compare_equal;
      next_flags[0] = compare_other;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= 8'h00;
    end else begin
      flags <= next_flags;
    end
  end

  a_flag_clear_wins: assert property (@(posedge clk) disable iff (sys_rst)
    (host_we && !flag_instruction && !compare_valid && host_wdata[15:8] != 8'h00)
      |=> ((flags & $past(host_wdata[15:8])) == 8'h00))
    else $error("flag clear did not win");
  a_flag_set_bits: assert property (@(posedge clk) disable iff (sys_rst)
    (host_we && !flag_instruction && !compare_valid && host_wdata[15:8] == 8'h00)
      |=> ((flags & $past(host_wdata[7:0])) == $past(host_wdata[7:0])))
    else $error("flag set lost");
endmodule : general_flags

// >>> host_model.sv
// Host processor model for the register bank's host port.
// Assumes one-cycle read and write strobes taken at the rising edge of clk.
`timescale 1ns/1ps
module host_model (
  // Clock.
  input wire logic clk,
  // Answers from the register bank.
  input wire logic [15:0] host_rdata,
  input wire logic host_hit,
  // Requests to the register bank.
  output logic host_rd,
  output logic host_wr,
  output logic [4:0] host_addr,
  output logic [15:0] host_wdata
);
  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 5'h04;
    host_wdata = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse of their last value, never a stale copy.
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = v;
    @(negedge clk);
    host_wr = 1'b0;
    host_addr = ~a;
    host_wdata = ~v;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] v, output logic hit);
    @(negedge clk);
    host_rd = 1'b1;
    host_addr = a;
    #1;
    hit = host_hit;
    @(negedge clk);
    host_rd = 1'b0;
    host_addr = ~a;
    v = host_rdata;
  endtask : rd
endmodule : host_model

// >>> tb_top.sv
// Self-checking bench of the condition, self-test and second enable register bank.
// Assumes the host model drives the host port; all other inputs come from here.
`timescale 1ns/1ps
module tb_top;
  import cond_regs_pkg::*;
  typedef struct {logic enh; logic [1:0] rt; logic [4:0] bad; logic [4:0] pt; logic [2:0] mt;
    logic [15:0] cc; logic [15:0] bs;} row_t;
  logic clk = 0, sys_rst = 1, enh = 0, done = 0, fi = 0, cv = 0, ce = 0, co = 0, rq = 0, h;
  logic [1:0] rt = 0;
  logic [4:0] bad = 0, pt = 0;
  logic [2:0] mt = 0;
  logic [15:0] fw = 0, rp = 0, ev = 0, d, en;
  wire host_rd, host_wr, host_hit;
  wire [4:0] host_addr;
  wire [15:0] host_wdata, host_rdata, st, ep, irq;
  int n_errors = 0, comparisons = 0;
  int bits[10] = '{14, 13, 12, 11, 10, 9, 8, 7, 6, 1};
  row_t rows[6] = '{
    '{0, 0, 5'h00, 5'h1f, 3'h7, 16'h0000, 16'hf8e0},
    '{1, 1, 5'h10, 5'h0a, 3'h2, 16'hb000, 16'h5040},
    '{1, 2, 5'h08, 5'h15, 3'h5, 16'hf000, 16'ha8a0},
    '{1, 3, 5'h14, 5'h00, 3'h0, 16'hf200, 16'h0000},
    '{1, 0, 5'h02, 5'h10, 3'h1, 16'h9100, 16'h8020},
    '{0, 1, 5'h11, 5'h01, 3'h4, 16'h3100, 16'h0880}};

  initial forever #25 clk = ~clk;

  host_model host_model_inst (.clk(clk), .host_rdata(host_rdata), .host_hit(host_hit),
    .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata));

  cond_self_test_done_event_irq_regs cond_self_test_done_event_irq_regs_inst (.clk(clk), .sys_rst(sys_rst),
    .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_hit(host_hit), .enhanced_controller_active(enh),
    .msg_done(done), .msg_retries(rt), .msg_error(bad[4]), .msg_loopback_fail(bad[3]),
    .msg_format_error(bad[2]), .msg_no_response(bad[1]), .msg_timeout(bad[0]),
    .flag_instruction(fi), .flag_instruction_word(fw), .compare_valid(cv),
    .compare_equal(ce), .compare_other(co), .proto_test_state(pt), .mem_test_state(mt),
    .instruction_parity_error(ev[14]), .illegal_command_event(ev[13]),
    .queue_rollover(ev[12]), .call_stack_error(ev[11]), .illegal_opcode_event(ev[10]),
    .term_cmd_stack_half(ev[9]), .term_circ_buffer_half(ev[8]),
    .monitor_cmd_stack_half(ev[7]), .monitor_data_stack_half(ev[6]),
    .request_instruction(rq), .request_parameter(rp), .self_test_done_event(ev[1]),
    .event_status(st), .event_pulse(ep), .interrupt_request(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic flags(input logic [15:0] exp);
    host_model_inst.rd(ADDR_COND_FLAGS, d, h);
    check("hit", {15'h0000, h}, 16'h0001);
    check("flags", d & 16'h00ff, exp);
  endtask : flags

  initial begin
    #(50 * 3000);
    n_errors++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) sys_rst = 0;
    host_model_inst.rd(ADDR_COND_FLAGS, d, h);
    check("cond reset", d, RESET_WORD);
    host_model_inst.rd(ADDR_INT_ENABLE2, d, h);
    check("enable reset", d, RESET_WORD);
    check("status reset", st, RESET_WORD);
    foreach (rows[i]) begin
      @(negedge clk);
      {enh, rt, bad, pt, mt} = {rows[i].enh, rows[i].rt, rows[i].bad, rows[i].pt, rows[i].mt};
      done = 1;
      @(negedge clk) done = 0;
      host_model_inst.rd(ADDR_COND_FLAGS, d, h);
      check("cond", d & 16'hf3ff, rows[i].cc);
      host_model_inst.rd(ADDR_SELF_TEST, d, h);
      check("self test", d, rows[i].bs);
    end
    host_model_inst.wr(ADDR_COND_FLAGS, 16'h00ff);
    flags(16'h00ff);
    host_model_inst.wr(ADDR_COND_FLAGS, 16'h0303);
    flags(16'h00fc);
    host_model_inst.wr(ADDR_COND_FLAGS, 16'hf000);
    flags(16'h000c);
    @(negedge clk) {fi, fw} = {1'b1, 16'h0c30};
    @(negedge clk) fi = 0;
    flags(16'h0030);
    @(negedge clk) {cv, ce, co} = 3'b111;
    @(negedge clk) cv = 0;
    flags(16'h0033);
    @(negedge clk) {cv, ce, co} = 3'b100;
    @(negedge clk) cv = 0;
    flags(16'h0030);
    host_model_inst.wr(ADDR_SELF_TEST, 16'hffff);
    host_model_inst.rd(ADDR_SELF_TEST, d, h);
    check("self test write", d, 16'h0880);
    host_model_inst.rd(5'h05, d, h);
    check("unmapped", {h, d[14:0]}, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      host_model_inst.wr(ADDR_INT_ENABLE2, p ? 16'haa4d : 16'hffff);
      en = p ? 16'h2a4c : ENABLE2_USED;
      host_model_inst.rd(ADDR_INT_ENABLE2, d, h);
      check("enable", d, en);
      foreach (bits[k]) begin
        @(negedge clk) ev = 16'h0001 << bits[k];
        @(negedge clk) ev = 0;
        check("irq", irq, (16'h0001 << bits[k]) & en);
        check("pulse", ep, 16'h0001 << bits[k]);
      end
      @(negedge clk) {rq, rp} = {1'b1, 16'hfff5};
      @(negedge clk) rq = 0;
      check("irq request", irq & 16'h003c, 16'h0014 & en);
      check("status request", st & 16'h003c, 16'h0014);
    end
    check("status", st, 16'h7fd6);
    @(negedge clk) sys_rst = 1;
    @(negedge clk) sys_rst = 0;
    check("status after reset", st, RESET_WORD);
    host_model_inst.rd(ADDR_COND_FLAGS, d, h);
    check("cond after reset", d, RESET_WORD);
    host_model_inst.rd(ADDR_INT_ENABLE2, d, h);
    check("enable after reset", d, RESET_WORD);
    end_of_test();
  end
endmodule : tb_top
